/* bench/fdsi_drive_checker.sv */
`timescale 1ns/1ps
module fdsi_drive_checker
    import fdsi_pkg::*;
(
    input wire logic               mclk,
    input wire logic               rst,
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic [DW-1:0]      hwdata,
    input wire logic               hready,
    input wire logic [DW-1:0]      hrdata,
    input wire logic               hreadyout,
    input wire logic               media_swapped_in,
    input wire logic               write_lock_in_n,
    input wire logic [N_UNITS-1:0] unit_pick_n_o,
    input wire logic [N_UNITS-1:0] unit_pick_n_oe_n,
    input wire logic [N_UNITS-1:0] spindle_on_n_o,
    input wire logic [N_UNITS-1:0] spindle_on_n_oe_n,
    input wire logic               rate_code_out_0,
    input wire logic               rate_code_out_1,
    input wire logic               rate_code_oe_n_0,
    input wire logic               rate_code_oe_n_1,
    input wire logic               write_permit
);
    logic take;
    logic ctrl_seen_r;
    logic rate_seen_r;
    assign take = hsel && htrans[TRANS_ACT_BIT] && hready;
    // set once software has written the word
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_seen_r <= 1'b0;
            rate_seen_r <= 1'b0;
        end else begin
            ctrl_seen_r <= ctrl_seen_r | (take && hwrite && haddr[AW-1:0] == CTRL_ADDR);
            rate_seen_r <= rate_seen_r | (take && hwrite && haddr[AW-1:0] == RATE_ADDR);
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_rate_wr;
        take && hwrite && haddr[AW-1:0] == RATE_ADDR;
    endsequence
    sequence s_chg_rd;
        take && !hwrite && haddr[AW-1:0] == CHANGE_ADDR && $stable(media_swapped_in);
    endsequence
    property p_pick_one;
        $countones(~unit_pick_n_oe_n) <= 1;
    endproperty
    a_pick_one: assert property (p_pick_one) else $error("two select lines pulled");
    property p_od_low;
        (unit_pick_n_o | spindle_on_n_o) == 4'h0;
    endproperty
    a_od_low: assert property (p_od_low) else $error("open drain drives high");
    property p_pick_rst;
        !ctrl_seen_r |-> unit_pick_n_oe_n == 4'hf && spindle_on_n_oe_n == 4'hf;
    endproperty
    a_pick_rst: assert property (p_pick_rst) else $error("line pulled before set");
    property p_rate_rst;
        !rate_seen_r |-> rate_code_oe_n_0 && rate_code_oe_n_1;
    endproperty
    a_rate_rst: assert property (p_rate_rst) else $error("rate pins driven early");
    property p_rate_pair;
        rate_code_oe_n_0 == rate_code_oe_n_1;
    endproperty
    a_rate_pair: assert property (p_rate_pair) else $error("rate drivers split");
    property p_rate_follow;
        s_rate_wr ##1 1'b1 |-> ##2 {rate_code_out_1, rate_code_out_0} == 2'($past(hwdata, 2));
    endproperty
    a_rate_follow: assert property (p_rate_follow) else $error("rate pins stale");
    property p_lock_refuse;
        !write_lock_in_n [*4] |-> !write_permit;
    endproperty
    a_lock_refuse: assert property (p_lock_refuse) else $error("write while locked");
    property p_permit_pulse;
        write_permit |=> !write_permit;
    endproperty
    a_permit_pulse: assert property (p_permit_pulse) else $error("permit too long");
    property p_change;
        s_chg_rd ##1 $stable(media_swapped_in) ##1 (hreadyout && $stable(media_swapped_in))
            |-> hrdata[CHANGE_BIT] == !media_swapped_in;
    endproperty
    a_change: assert property (p_change) else $error("change bit wrong");
endmodule

/* bench/fdsi_drive_model.sv */
`timescale 1ns/1ps
module fdsi_drive_model
    import fdsi_pkg::*;
(
    input  wire logic               chg,
    input  wire logic               lock,
    input  wire logic               trk,
    input  wire logic               idx,
    input  wire logic [1:0]         kind,
    input  wire logic [N_UNITS-1:0] pick_o,
    input  wire logic [N_UNITS-1:0] pick_oe_n,
    input  wire logic [N_UNITS-1:0] spin_o,
    input  wire logic [N_UNITS-1:0] spin_oe_n,
    input  wire logic               cls_o,
    input  wire logic               cls_oe_n,
    input  wire logic               rc0,
    input  wire logic               rc1,
    input  wire logic               rc_oe0,
    input  wire logic               rc_oe1,
    output logic                    swap_n,
    output logic                    lock_n,
    output logic                    trk_n,
    output logic                    idx_n,
    output logic      [N_UNITS-1:0] pick_i,
    output logic      [N_UNITS-1:0] spin_i,
    output logic                    cls_i,
    output logic                    kind0,
    output logic                    kind1
);
    assign swap_n = !chg;
    assign lock_n = !lock;
    assign trk_n  = !trk;
    assign idx_n  = !idx;
    // cable pull-ups win wherever a driver lets go
    assign pick_i = pick_oe_n | pick_o;
    assign spin_i = spin_oe_n | spin_o;
    assign cls_i  = cls_oe_n | cls_o;
    // drive shows its medium kind on released rate lines
    assign kind0  = rc_oe0 ? kind[0] : rc0;
    assign kind1  = rc_oe1 ? kind[1] : rc1;
endmodule

/* bench/test_floppy_drive_signal_interface.sv */
`timescale 1ns/1ps
module test_floppy_drive_signal_interface;
    import fdsi_pkg::*;
    logic               mclk, rst, hsel, hwrite, chg, lock, trk, idx, seen;
    logic               hreadyout, hresp, swn, lkn, trn, ixn, cl_i, cl_o, cl_oe;
    logic               k0, k1, r0, r1, ro0, ro1, wp, irq;
    logic [1:0]         htrans, kind;
    logic [2:0]         hsize;
    logic [7:0]         rnd;
    logic [31:0]        haddr, hwdata, hrdata, q;
    logic [N_UNITS-1:0] pk_i, pk_o, pk_oe, sp_i, sp_o, sp_oe;
    logic [11:0]        ra[6] = '{CTRL_ADDR, RATE_ADDR, CONF_ADDR, ISTAT_ADDR, IMASK_ADDR, 12'h0f0};
    logic [31:0]        rv[6] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
    int                 n_errors = 0, n_checks = 0, cyc = 0;

    fdsi_drive_if i_fdsi_drive_if (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .media_swapped_in(swn),
        .write_lock_in_n(lkn), .outer_track_in_n(trn), .track_start_in_n(ixn),
        .unit_pick_n_i(pk_i), .unit_pick_n_o(pk_o), .unit_pick_n_oe_n(pk_oe),
        .spindle_on_n_i(sp_i), .spindle_on_n_o(sp_o), .spindle_on_n_oe_n(sp_oe),
        .rate_class_in(cl_i), .rate_class_out(cl_o), .rate_class_oe_n(cl_oe),
        .medium_kind_in_0(k0), .medium_kind_in_1(k1), .rate_code_out_0(r0),
        .rate_code_out_1(r1), .rate_code_oe_n_0(ro0), .rate_code_oe_n_1(ro1),
        .write_permit(wp), .irq);
    fdsi_drive_model i_fdsi_drive_model (.chg, .lock, .trk, .idx, .kind, .pick_o(pk_o),
        .pick_oe_n(pk_oe), .spin_o(sp_o), .spin_oe_n(sp_oe), .cls_o(cl_o), .cls_oe_n(cl_oe),
        .rc0(r0), .rc1(r1), .rc_oe0(ro0), .rc_oe1(ro1), .swap_n(swn), .lock_n(lkn),
        .trk_n(trn), .idx_n(ixn), .pick_i(pk_i), .spin_i(sp_i), .cls_i(cl_i), .kind0(k0),
        .kind1(k1));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    function logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function logic [3:0] exp_pick(input logic [1:0] u);
        return ~(4'h1 << u);
    endfunction
    // density pin released when high rate matches ident
    function logic exp_dens(input logic [1:0] r, input logic id);
        return ((r == 2'h0) || (r == 2'h3)) == id;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    initial begin
        {rst, hsel, hwrite, chg, lock, trk, idx} = 7'h40;
        {htrans, kind, haddr, hwdata} = '0;
        hsize = SIZE_WORD;
        rnd = 8'h29;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        wt(1);
        chk(32'({pk_oe, sp_oe, ro0, ro1}), 32'h3ff);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, ra[i], 32'h0, q);
            chk(q, rv[i]);
        end
        $display("reset test done");
        for (int u = 0; u < 4; u++) begin
            rnd = lfsr(rnd);
            bus(1'b1, CTRL_ADDR, 32'({rnd[7:4], 2'b01, u[1:0]}), q);
            wt(3);
            chk(32'({sp_oe, pk_oe}), 32'({~rnd[7:4], exp_pick(u[1:0])}));
            bus(1'b0, PINS_ADDR, 32'h0, q);
            chk(32'(q[7:0]), 32'({~rnd[7:4], exp_pick(u[1:0])}));
        end
        bus(1'b1, CTRL_ADDR, 32'h0, q);
        wt(3);
        chk(32'({sp_oe, pk_oe}), 32'hff);
        $display("select test done");
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, CONF_ADDR, 32'(i[2]), q);
            bus(1'b1, RATE_ADDR, 32'(i[1:0]), q);
            wt(3);
            chk(32'({ro1, ro0, r1, r0}), 32'(i[1:0]));
            chk(32'({hresp, cl_o, cl_oe}), 32'(exp_dens(i[1:0], i[2])));
        end
        rnd = lfsr(rnd);
        kind <= rnd[1:0];
        bus(1'b1, CONF_ADDR, 32'h3, q);
        wt(3);
        chk(32'({ro1, ro0}), 32'h3);
        bus(1'b0, TAPE_ADDR, 32'h0, q);
        chk(32'(q[7:6]), 32'(rnd[1:0]));
        bus(1'b1, CONF_ADDR, 32'h1, q);
        $display("rate test done");
        for (int e = 0; e < 3; e++) begin
            {trk, chg, idx} <= 3'h1 << e;
            wt(2);
            idx <= 1'b0;
            wt(5);
            bus(1'b0, CHANGE_ADDR, 32'h0, q);
            chk(32'(q[CHANGE_BIT]), 32'(e == 1));
            bus(1'b0, LINE_ADDR, 32'h0, q);
            chk(32'(q[3:0]), 32'({lock, trk, chg, idx}));
            bus(1'b0, ISTAT_ADDR, 32'h0, q);
            chk(32'({q[e], irq}), 32'h2);
            bus(1'b1, IMASK_ADDR, 32'h1 << e, q);
            wt(3);
            chk(32'(irq), 32'h1);
            bus(1'b1, ISTAT_ADDR, 32'h1 << e, q);
            wt(3);
            chk(32'(irq), 32'h0);
            bus(1'b1, IMASK_ADDR, 32'h0, q);
        end
        $display("event test done");
        for (int i = 0; i < 2; i++) begin
            lock <= (i == 0);
            wt(4);
            bus(1'b1, WCMD_ADDR, 32'h1, q);
            seen = 1'b0;
            repeat (6) begin
                wt(1);
                seen = seen | wp;
            end
            chk(32'(seen), 32'(i));
            bus(1'b0, ISTAT_ADDR, 32'h0, q);
            chk(32'(q[EV_REFUSED]), 32'(i == 0));
            bus(1'b1, ISTAT_ADDR, 32'h8, q);
        end
        $display("write lock test done");
        end_sim();
    end
endmodule

bind fdsi_drive_if fdsi_drive_checker i_fdsi_drive_checker (.mclk, .rst, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .media_swapped_in,
    .write_lock_in_n, .unit_pick_n_o, .unit_pick_n_oe_n, .spindle_on_n_o, .spindle_on_n_oe_n,
    .rate_code_out_0, .rate_code_out_1, .rate_code_oe_n_0, .rate_code_oe_n_1, .write_permit);

/* common/fdsi_pkg.sv */
package fdsi_pkg;
    localparam int unsigned AW = 12;
    localparam int unsigned DW = 32;
    localparam int unsigned N_UNITS = 4;
    localparam int unsigned UNIT_W = 2;
    localparam int unsigned N_EV = 4;
    localparam int unsigned N_SENSE = 4;

    // byte addresses of the register words
    localparam logic [AW-1:0] CTRL_ADDR = 12'h000;
    localparam logic [AW-1:0] RATE_ADDR = 12'h004;
    localparam logic [AW-1:0] CONF_ADDR = 12'h008;
    localparam logic [AW-1:0] TAPE_ADDR = 12'h010;
    localparam logic [AW-1:0] LINE_ADDR = 12'h014;
    localparam logic [AW-1:0] ISTAT_ADDR = 12'h018;
    localparam logic [AW-1:0] IMASK_ADDR = 12'h01c;
    localparam logic [AW-1:0] WCMD_ADDR = 12'h020;
    localparam logic [AW-1:0] PINS_ADDR = 12'h024;
    // change word: byte address is its index times four
    localparam logic [11:0] CHANGE_IDX = 12'h3f7;
    localparam logic [AW-1:0] CHANGE_ADDR = {CHANGE_IDX[9:0], 2'b00};

    // field positions
    localparam int unsigned CTRL_UNIT_LSB = 0;
    localparam int unsigned CTRL_PICK_BIT = 2;
    localparam int unsigned CTRL_SPIN_LSB = 4;
    localparam int unsigned RATE_LSB = 0;
    localparam int unsigned CONF_IDENT_BIT = 0;
    localparam int unsigned CONF_MODE2_BIT = 1;
    localparam int unsigned CHANGE_BIT = 7;
    localparam int unsigned TAPE_KIND_LSB = 6;
    localparam int unsigned WCMD_GO_BIT = 0;
    localparam int unsigned PINS_SPIN_LSB = 4;
    localparam int unsigned PINS_CLASS_BIT = 8;

    // event bits of status and mask
    localparam int unsigned EV_INDEX = 0;
    localparam int unsigned EV_SWAP = 1;
    localparam int unsigned EV_TRACK0 = 2;
    localparam int unsigned EV_REFUSED = 3;

    // sense vector positions
    localparam int unsigned SN_INDEX = 0;
    localparam int unsigned SN_SWAP = 1;
    localparam int unsigned SN_TRACK0 = 2;
    localparam int unsigned SN_LOCK = 3;

    // rate codes
    localparam logic [1:0] RATE_500K = 2'h0;
    localparam logic [1:0] RATE_1M = 2'h3;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] RATE_RST = 2'h0;
    localparam logic [1:0] CONF_RST = 2'h1;
    localparam logic [N_EV-1:0] EV_RST = 4'h0;

    // bus
    localparam int unsigned TRANS_ACT_BIT = 1;
    localparam logic [2:0] SIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        WR_IDLE  = 2'b00,
        WR_CHECK = 2'b01,
        WR_GRANT = 2'b10
    } fdsi_wr_state_t;
endpackage

/* common/fdsi_regbus_if.sv */
`timescale 1ns/1ps
interface fdsi_regbus_if;
    import fdsi_pkg::*;
    logic          wr_en;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport front (output wr_en, output addr, output wdata, input rdata);
    modport regs  (input wr_en, input addr, input wdata, output rdata);
endinterface

/* rtl/fdsi_ahb_slave.sv */
`timescale 1ns/1ps
module fdsi_ahb_slave
    import fdsi_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [DW-1:0] hwdata,
    input  wire logic          hready,
    output logic      [DW-1:0] hrdata,
    output logic               hreadyout,
    output logic               hresp,
    fdsi_regbus_if.front       rb
);
    logic          take;
    logic          wr_pend_r;
    logic          rd_pend_r;
    logic [AW-1:0] addr_r;

    assign take = hsel & htrans[TRANS_ACT_BIT] & hready;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= '0;
            hresp     <= 1'b0;
        end else begin
            hresp     <= 1'b0;
            // only whole-word writes reach the registers
            wr_pend_r <= take & hwrite & (hsize == SIZE_WORD);
            rd_pend_r <= take & ~hwrite;
            if (take) begin
                addr_r <= haddr[AW-1:0];
            end
        end
    end

    // reads take one wait state so the read data leave a flop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hrdata    <= '0;
        end else if (take & ~hwrite) begin
            hreadyout <= 1'b0;
        end else if (rd_pend_r) begin
            hreadyout <= 1'b1;
            hrdata    <= rb.rdata;
        end
    end

    assign rb.wr_en = wr_pend_r;
    assign rb.addr  = rd_pend_r | wr_pend_r ? addr_r : '0;
    assign rb.wdata = hwdata;
endmodule

/* rtl/fdsi_drive_if.sv */
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// - disk-change reads back inverted as bit 7 of the change word.
// - only the chosen unit's open-drain select line of four is pulled low.
// - each running unit's open-drain motor line of four is pulled low.
// - the density line tells low from high rate, ident sets its polarity.
// - while write-protect is active every write command is refused.
// - the rate-code lines follow bits 0 and 1 of the rate register.
// - from reset the rate-code lines are left undriven.
// - in mode 2 the rate pins are medium-kind inputs read as tape bits 6 and 7.
module fdsi_drive_if
    import fdsi_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [DW-1:0]      hwdata,
    input  wire logic               hready,
    output logic      [DW-1:0]      hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic               media_swapped_in,
    input  wire logic               write_lock_in_n,
    input  wire logic               outer_track_in_n,
    input  wire logic               track_start_in_n,
    input  wire logic [N_UNITS-1:0] unit_pick_n_i,
    output logic      [N_UNITS-1:0] unit_pick_n_o,
    output logic      [N_UNITS-1:0] unit_pick_n_oe_n,
    input  wire logic [N_UNITS-1:0] spindle_on_n_i,
    output logic      [N_UNITS-1:0] spindle_on_n_o,
    output logic      [N_UNITS-1:0] spindle_on_n_oe_n,
    input  wire logic               rate_class_in,
    output logic                    rate_class_out,
    output logic                    rate_class_oe_n,
    input  wire logic               medium_kind_in_0,
    input  wire logic               medium_kind_in_1,
    output logic                    rate_code_out_0,
    output logic                    rate_code_out_1,
    output logic                    rate_code_oe_n_0,
    output logic                    rate_code_oe_n_1,
    output logic                    write_permit,
    output logic                    irq
);
    fdsi_regbus_if rb ();

    fdsi_ahb_slave u_slave (
        .mclk      (mclk),
        .rst       (rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rb        (rb.front)
    );

    // registered drive lines and their falling steps
    logic [N_SENSE-1:0] sense_pin_n;
    logic [N_SENSE-1:0] sense_lvl_n;
    logic [N_SENSE-1:0] sense_fall;

    assign sense_pin_n[SN_INDEX]  = track_start_in_n;
    assign sense_pin_n[SN_SWAP]   = media_swapped_in;
    assign sense_pin_n[SN_TRACK0] = outer_track_in_n;
    assign sense_pin_n[SN_LOCK]   = write_lock_in_n;

    fdsi_edge_sense #(
        .W (N_SENSE)
    ) u_sense (
        .mclk    (mclk),
        .rst     (rst),
        .pin_n   (sense_pin_n),
        .lvl_n_r (sense_lvl_n),
        .fall_r  (sense_fall)
    );

    // register state
    logic [UNIT_W-1:0]  unit_sel_r;
    logic               pick_en_r;
    logic [N_UNITS-1:0] spin_r;
    logic [1:0]         rate_r;
    logic               rate_drive_r;
    logic               ident_r;
    logic               mode2_r;
    logic [N_EV-1:0]    ev_stat_r;
    logic [N_EV-1:0]    ev_mask_r;
    logic [N_EV-1:0]    ev_stat_nxt;
    logic [N_EV-1:0]    ev_set;
    logic               wcmd_go;
    logic               refused_r;
    logic               high_rate;
    logic               class_level;
    fdsi_wr_state_t     wr_state_r;
    fdsi_wr_state_t     wr_state_nxt;

    // write strobes per register
    logic wr_ctrl;
    logic wr_rate;
    logic wr_conf;
    logic wr_istat;
    logic wr_imask;
    logic wr_wcmd;

    assign wr_ctrl  = rb.wr_en & (rb.addr == CTRL_ADDR);
    assign wr_rate  = rb.wr_en & (rb.addr == RATE_ADDR);
    assign wr_conf  = rb.wr_en & (rb.addr == CONF_ADDR);
    assign wr_istat = rb.wr_en & (rb.addr == ISTAT_ADDR);
    assign wr_imask = rb.wr_en & (rb.addr == IMASK_ADDR);
    assign wr_wcmd  = rb.wr_en & (rb.addr == WCMD_ADDR);

    assign wcmd_go = wr_wcmd & rb.wdata[WCMD_GO_BIT];

    // unit control word
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            unit_sel_r <= CTRL_RST[CTRL_UNIT_LSB +: UNIT_W];
            pick_en_r  <= CTRL_RST[CTRL_PICK_BIT];
            spin_r     <= CTRL_RST[CTRL_SPIN_LSB +: N_UNITS];
        end else if (wr_ctrl) begin
            unit_sel_r <= rb.wdata[CTRL_UNIT_LSB +: UNIT_W];
            pick_en_r  <= rb.wdata[CTRL_PICK_BIT];
            spin_r     <= rb.wdata[CTRL_SPIN_LSB +: N_UNITS];
        end
    end

    // rate register; the first write turns the rate-code drivers on
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rate_r       <= RATE_RST;
            rate_drive_r <= 1'b0;
        end else if (wr_rate) begin
            rate_r       <= rb.wdata[RATE_LSB +: 2];
            rate_drive_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ident_r <= CONF_RST[CONF_IDENT_BIT];
            mode2_r <= CONF_RST[CONF_MODE2_BIT];
        end else if (wr_conf) begin
            ident_r <= rb.wdata[CONF_IDENT_BIT];
            mode2_r <= rb.wdata[CONF_MODE2_BIT];
        end
    end

    // open-drain select and motor lines, one slice per unit
    for (genvar u = 0; u < N_UNITS; u++) begin : g_unit
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                unit_pick_n_oe_n[u]  <= 1'b1;
                spindle_on_n_oe_n[u] <= 1'b1;
                unit_pick_n_o[u]     <= 1'b0;
                spindle_on_n_o[u]    <= 1'b0;
            end else begin
                unit_pick_n_oe_n[u]  <= ~(pick_en_r & (unit_sel_r == UNIT_W'(u)));
                spindle_on_n_oe_n[u] <= ~spin_r[u];
                unit_pick_n_o[u]     <= 1'b0;
                spindle_on_n_o[u]    <= 1'b0;
            end
        end
    end

    // density pin, ident flips the sense
    assign high_rate   = (rate_r == RATE_500K) | (rate_r == RATE_1M);
    assign class_level = high_rate ~^ ident_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rate_class_oe_n <= 1'b1;
            rate_class_out  <= 1'b0;
        end else begin
            rate_class_oe_n <= class_level;
            rate_class_out  <= 1'b0;
        end
    end

    // rate-code pins, released in mode 2
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rate_code_out_0  <= 1'b0;
            rate_code_out_1  <= 1'b0;
            rate_code_oe_n_0 <= 1'b1;
            rate_code_oe_n_1 <= 1'b1;
        end else begin
            rate_code_out_0  <= rate_r[0];
            rate_code_out_1  <= rate_r[1];
            rate_code_oe_n_0 <= ~rate_drive_r | mode2_r;
            rate_code_oe_n_1 <= ~rate_drive_r | mode2_r;
        end
    end

    // write command gate
    always_comb begin
        wr_state_nxt = wr_state_r;
        case (wr_state_r)
            WR_IDLE: begin
                if (wcmd_go) begin
                    wr_state_nxt = WR_CHECK;
                end
            end
            WR_CHECK: begin
                if (sense_lvl_n[SN_LOCK]) begin
                    wr_state_nxt = WR_GRANT;
                end else begin
                    wr_state_nxt = WR_IDLE;
                end
            end
            WR_GRANT: begin
                wr_state_nxt = WR_IDLE;
            end
            default: begin
                wr_state_nxt = WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_state_r <= WR_IDLE;
        end else begin
            wr_state_r <= wr_state_nxt;
        end
    end

    // a grant leaves only if the registered lock level is inactive in WR_CHECK
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            write_permit <= 1'b0;
            refused_r    <= 1'b0;
        end else begin
            write_permit <= (wr_state_r == WR_CHECK) & sense_lvl_n[SN_LOCK];
            refused_r    <= (wr_state_r == WR_CHECK) & ~sense_lvl_n[SN_LOCK];
        end
    end

    // sticky events, set wins over a clear in the same cycle
    always_comb begin
        ev_set             = '0;
        ev_set[EV_INDEX]   = sense_fall[SN_INDEX];
        ev_set[EV_SWAP]    = sense_fall[SN_SWAP];
        ev_set[EV_TRACK0]  = sense_fall[SN_TRACK0];
        ev_set[EV_REFUSED] = refused_r;
        ev_stat_nxt        = ev_stat_r;
        if (wr_istat) begin
            ev_stat_nxt = ev_stat_r & ~rb.wdata[N_EV-1:0];
        end
        ev_stat_nxt = ev_stat_nxt | ev_set;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ev_stat_r <= EV_RST;
        end else begin
            ev_stat_r <= ev_stat_nxt;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ev_mask_r <= EV_RST;
        end else if (wr_imask) begin
            ev_mask_r <= rb.wdata[N_EV-1:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ev_stat_r & ev_mask_r);
        end
    end

    // read mux; unmapped words read as zero
    always_comb begin
        rb.rdata = '0;
        case (rb.addr)
            CTRL_ADDR: begin
                rb.rdata[CTRL_UNIT_LSB +: UNIT_W] = unit_sel_r;
                rb.rdata[CTRL_PICK_BIT]           = pick_en_r;
                rb.rdata[CTRL_SPIN_LSB +: N_UNITS] = spin_r;
            end
            RATE_ADDR: begin
                rb.rdata[RATE_LSB +: 2] = rate_r;
            end
            CONF_ADDR: begin
                rb.rdata[CONF_IDENT_BIT] = ident_r;
                rb.rdata[CONF_MODE2_BIT] = mode2_r;
            end
            CHANGE_ADDR: begin
                rb.rdata[CHANGE_BIT] = ~sense_lvl_n[SN_SWAP];
            end
            TAPE_ADDR: begin
                if (mode2_r) begin
                    rb.rdata[TAPE_KIND_LSB]     = medium_kind_in_0;
                    rb.rdata[TAPE_KIND_LSB + 1] = medium_kind_in_1;
                end
            end
            LINE_ADDR: begin
                rb.rdata[SN_INDEX]  = ~sense_lvl_n[SN_INDEX];
                rb.rdata[SN_SWAP]   = ~sense_lvl_n[SN_SWAP];
                rb.rdata[SN_TRACK0] = ~sense_lvl_n[SN_TRACK0];
                rb.rdata[SN_LOCK]   = ~sense_lvl_n[SN_LOCK];
            end
            ISTAT_ADDR: begin
                rb.rdata[N_EV-1:0] = ev_stat_r;
            end
            IMASK_ADDR: begin
                rb.rdata[N_EV-1:0] = ev_mask_r;
            end
            PINS_ADDR: begin
                rb.rdata[N_UNITS-1:0]               = unit_pick_n_i;
                rb.rdata[PINS_SPIN_LSB +: N_UNITS]  = spindle_on_n_i;
                rb.rdata[PINS_CLASS_BIT]            = rate_class_in;
            end
            default: begin
                rb.rdata = '0;
            end
        endcase
    end
endmodule

/* rtl/fdsi_edge_sense.sv */
`timescale 1ns/1ps
module fdsi_edge_sense
    import fdsi_pkg::*;
#(
    parameter int unsigned W = 4
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin_n,
    output logic      [W-1:0] lvl_n_r,
    output logic      [W-1:0] fall_r
);
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                lvl_n_r[i] <= 1'b1;
                fall_r[i]  <= 1'b0;
            end else begin
                lvl_n_r[i] <= pin_n[i];
                // one pulse per high-to-low step of the line
                fall_r[i]  <= lvl_n_r[i] & ~pin_n[i];
            end
        end
    end
endmodule
